// File: rtl/afda_pkg.sv
// Shared constants, types and decode functions of the datapath.
// Assumes a single clock domain; every user imports the whole package.
package afda_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned FLAGS_W = 5;
	localparam int unsigned NPTR    = 3;
	localparam int unsigned BANK_W  = 4;

	// ----------------------------------------------------------------
	// APB register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_ACC   = 8'h04;
	localparam logic [7:0] OFS_BANK  = 8'h08;
	localparam logic [7:0] OFS_PTR0  = 8'h0C;
	localparam logic [7:0] OFS_PTR1  = 8'h10;
	localparam logic [7:0] OFS_PTR2  = 8'h14;
	localparam logic [7:0] OFS_CFG   = 8'h18;
	localparam logic [7:0] OFS_STAT  = 8'h1C;

	// ----------------------------------------------------------------
	// Flag bit positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FL_C  = 0;
	localparam int unsigned FL_DC = 1;
	localparam int unsigned FL_Z  = 2;
	localparam int unsigned FL_OV = 3;
	localparam int unsigned FL_N  = 4;
	localparam int unsigned CFG_EXT = 0;

	localparam logic [4:0]  FLAGS_RST = 5'h00;
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [3:0]  BANK_RST  = 4'h0;
	localparam logic [11:0] PTR_RST   = 12'h000;
	localparam logic        CFG_RST   = 1'b0;

	// ----------------------------------------------------------------
	// Data-space map of the core's own registers
	// ----------------------------------------------------------------
	localparam logic [11:0] SFR_PTR_BASE  = 12'hFC0;
	localparam logic [11:0] SFR_PTR_TOP   = 12'hFC5;
	localparam logic [11:0] SFR_VIRT_BASE = 12'hFD0;
	localparam logic [11:0] SFR_VIRT_TOP  = 12'hFE7;
	localparam logic [11:0] SFR_FLAGS     = 12'hFF0;
	localparam logic [11:0] SFR_ACC       = 12'hFF1;
	localparam logic [11:0] SFR_BANK      = 12'hFF2;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
	localparam logic [3:0]  ACCESS_HI_PG  = 4'hF;
	localparam logic [3:0]  ACCESS_LO_PG  = 4'h0;
	localparam logic [7:0]  IDX_LIMIT     = 8'h5F;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_ADDL, OP_SUBL, OP_AND, OP_IOR, OP_XOR,
		OP_MOVF, OP_CLR, OP_RLC, OP_RRC, OP_STORE, OP_MOVL, OP_LJMP
	} afda_op_e;

	typedef enum logic [2:0] {IND_PLAIN, IND_AFTER_ACCESS_INCREMENT, IND_AFTER_ACCESS_DECREMENT, IND_BEFORE_ACCESS_INCREMENT, IND_ACCUMULATOR_OFFSET_OPERAND} afda_ind_e;
	typedef enum logic [2:0] {SEL_RAM, SEL_FLAGS, SEL_ACC, SEL_BANK, SEL_PTR_LO, SEL_PTR_HI} afda_sel_e;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WRITE} afda_state_e;

	// Which flags an operation may change; all others are left alone.
	function automatic logic [4:0] afda_flag_mask(input afda_op_e op);
		case (op)
			OP_ADD, OP_SUB, OP_ADDL, OP_SUBL: afda_flag_mask = 5'h1F;
			OP_AND, OP_IOR, OP_XOR, OP_MOVF:  afda_flag_mask = 5'h14;
			OP_CLR:                           afda_flag_mask = 5'h04;
			OP_RLC, OP_RRC:                   afda_flag_mask = 5'h17;
			default:                          afda_flag_mask = 5'h00;
		endcase
	endfunction

	function automatic logic afda_is_literal(input afda_op_e op);
		afda_is_literal = (op == OP_ADDL) || (op == OP_SUBL) || (op == OP_MOVL) ||
			(op == OP_NOP) || (op == OP_LJMP);
	endfunction

endpackage

// File: rtl/afda_alu_if.sv
// Operand and result bundle between the addressing core and its ALU.
// Assumes one clock domain; the bundle is purely combinational.
`timescale 1ns/1ns
`default_nettype none
interface afda_alu_if;
	import afda_pkg::*;
	afda_op_e   op;
	logic [7:0] a;
	logic [7:0] b;
	logic       carry_in;
	logic [7:0] result;
	logic [4:0] flags;
	logic [4:0] mask;
	modport core (output op, a, b, carry_in, input result, flags, mask);
	modport alu  (input op, a, b, carry_in, output result, flags, mask);
endinterface
`default_nettype wire

// File: rtl/afda_alu.sv
// Combinational 8-bit ALU: result, candidate flags and the mask of touched flags.
// Assumes the caller merges the masked flags into the flag register.
`timescale 1ns/1ns
`default_nettype none
module afda_alu (
	afda_alu_if.alu bus // Operands in, result and flags out.
);
	import afda_pkg::*;

	logic [7:0] b_eff;
	logic       cin;
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] res;
	logic       c;
	logic       dc;
	logic       ov;

	always_comb begin
		b_eff = bus.b;
		cin   = 1'b0;
		sum   = 9'h000;
		low   = 5'h00;
		res   = bus.a;
		c     = 1'b0;
		dc    = 1'b0;
		ov    = 1'b0;
		case (bus.op)
			OP_ADD, OP_ADDL, OP_SUB, OP_SUBL: begin
				// Subtraction adds the two's complement, so both carries read as not-borrow.
				if (bus.op == OP_SUB || bus.op == OP_SUBL) begin
					b_eff = ~bus.b;
					cin   = 1'b1;
				end
				sum = {1'b0, bus.a} + {1'b0, b_eff} + {8'h00, cin};
				low = {1'b0, bus.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
				res = sum[7:0];
				dc  = low[4];
				c   = sum[8];
				ov  = (bus.a[7] == b_eff[7]) && (res[7] != bus.a[7]);
			end
			OP_AND:   res = bus.a & bus.b;
			OP_IOR:   res = bus.a | bus.b;
			OP_XOR:   res = bus.a ^ bus.b;
			OP_CLR:   res = 8'h00;
			OP_STORE: res = bus.b;
			OP_RLC: begin
				res = {bus.a[6:0], bus.carry_in};
				c   = bus.a[7];
				dc  = bus.a[3];
			end
			OP_RRC: begin
				res = {bus.carry_in, bus.a[7:1]};
				c   = bus.a[0];
				dc  = bus.a[4];
			end
			default: res = bus.a;
		endcase
	end

	assign bus.result = res;
	assign bus.flags  = {res[7], ov, (res == 8'h00), dc, c};
	assign bus.mask   = afda_flag_mask(bus.op);

endmodule
`default_nettype wire

// File: rtl/afda_core.sv
// Flag register, operand addressing and write-back of the 8-bit datapath, with an APB slave.
// Assumes a decoder offering one instruction at a time and a RAM with combinational reads.
//
// Contract
// - flag target takes flag effects, not result (the code loads result bits 4..0 when the operation's flag mask is zero)
// - clearing flags sets zero, keeps others
// - flag bits 7..5 read as zero
// - sign flag copies result bit 7
// - wrap flag marks signed overflow
// - nil flag set on zero result
// - half carry from bit 3 carry
// - full carry from bit 7 carry
// - subtract by adding two's complement
// - rotate loads half carry from bit 4/3 (the code takes bit 3 on a left rotate and bit 4 on a right rotate)
// - rotate loads carry from MSB/LSB
// - four modes; indexed only with extended bit
// - long jump carries 20-bit target
// - file address is opcode low byte
// - access bit 1 uses bank pointer
// - access bit 0 maps access bank
// - full 12-bit address ignores bank
// - destination bit picks file or accumulator
// - no destination bit uses implicit target
// - pointers mapped in register space
// - indirect operands update or offset pointer
// - pointer is twelve bits, two halves
// - post increment, post decrement, pre increment
// - pointer carries across halves, flags untouched
// - indirect address ignores bank and access
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module afda_core
	import afda_pkg::*;
#(
	parameter int unsigned N_PTR = NPTR
) (
	input  wire logic              pclk,           // APB and core clock.
	input  wire logic              presetn,        // Asynchronous reset, active low.
	input  wire logic              psel,           // APB select.
	input  wire logic              penable,        // APB access phase.
	input  wire logic              pwrite,         // APB direction, high for write.
	input  wire logic [7:0]        paddr,          // APB byte address.
	input  wire logic [31:0]       pwdata,         // APB write data.
	output logic      [31:0]       prdata,         // APB read data.
	output logic                   pready,         // APB ready.
	output logic                   pslverr,        // APB error on unmapped address.
	input  wire logic              instr_valid,    // Decoder offers an instruction.
	output logic                   instr_ready,    // Core can take an instruction.
	input  wire afda_pkg::afda_op_e instr_op,      // Operation.
	input  wire logic [7:0]        instr_file,     // Opcode low byte: file address or literal.
	input  wire logic              instr_access,   // Access-select bit.
	input  wire logic              instr_dest,     // Destination bit.
	input  wire logic              instr_has_dest, // Instruction carries a destination bit.
	input  wire logic              instr_impl_file,// Implicit target is the file register.
	input  wire logic              instr_full,     // Instruction embeds a full data address.
	input  wire logic [11:0]       instr_full_addr,// Embedded full data address.
	input  wire logic [11:0]       instr_jump_hi,  // Upper target bits of a long jump.
	output logic                   instr_done,     // Instruction finished.
	output logic                   jump_valid,     // Long jump target is presented.
	output logic      [19:0]       jump_target,    // Long jump program address.
	output logic      [11:0]       mem_addr,       // Data RAM address.
	output logic                   mem_re,         // Data RAM read.
	output logic                   mem_we,         // Data RAM write.
	output logic      [7:0]        mem_wdata,      // Data RAM write data.
	input  wire logic [7:0]        mem_rdata       // Data RAM read data.
);
	import afda_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	afda_state_e state;
	logic [4:0]  flags;
	logic [7:0]  acc;
	logic [3:0]  bank;
	logic [11:0] ptr [N_PTR];
	logic        ext_en;
	afda_op_e    op_q;
	logic [7:0]  lit_q;
	logic        wr_file_q;
	afda_sel_e   sel_q;
	logic [1:0]  sel_idx_q;
	logic [11:0] next_addr;
	logic [11:0] raw_addr;
	logic        virt_hit;
	logic [1:0]  virt_idx;
	afda_ind_e   virt_kind;
	logic [11:0] virt_ptr;
	logic [11:0] next_ptr_val;
	logic        take;
	logic [7:0]  src;
	logic        wr_acc;
	logic        flag_target;
	logic        apb_wr;
	logic        apb_hit;
	logic [7:0]  rd_mux;

	afda_alu_if alu_bus ();
	afda_alu u_alu (.bus(alu_bus));

	// Which core register, if any, a data address names.
	function automatic afda_sel_e sfr_sel(input logic [11:0] a);
		if (a == SFR_FLAGS)
			sfr_sel = SEL_FLAGS;
		else if (a == SFR_ACC)
			sfr_sel = SEL_ACC;
		else if (a == SFR_BANK)
			sfr_sel = SEL_BANK;
		else if (a >= SFR_PTR_BASE && a <= SFR_PTR_TOP)
			sfr_sel = a[0] ? SEL_PTR_HI : SEL_PTR_LO;
		else
			sfr_sel = SEL_RAM;
	endfunction

	assign instr_ready = (state == ST_IDLE);
	assign take        = instr_valid && instr_ready;

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	always_comb begin
		if (instr_full)
			raw_addr = instr_full_addr;
		else if (ext_en && !instr_access && instr_file <= IDX_LIMIT)
			raw_addr = ptr[2] + {4'h0, instr_file};
		else if (instr_access)
			raw_addr = {bank, instr_file};
		else if (instr_file >= ACCESS_SPLIT)
			raw_addr = {ACCESS_HI_PG, instr_file};
		else
			raw_addr = {ACCESS_LO_PG, instr_file};
	end

	// Each pointer owns eight virtual operands; the first five select a mode, the last three act as the plain one.
	always_comb begin
		virt_hit  = (raw_addr >= SFR_VIRT_BASE) && (raw_addr <= SFR_VIRT_TOP);
		virt_idx  = 2'(raw_addr[4:3] - SFR_VIRT_BASE[4:3]);
		virt_kind = IND_PLAIN;
		if (virt_hit && raw_addr[2:0] <= 3'd4)
			virt_kind = afda_ind_e'(raw_addr[2:0]);
		virt_ptr  = ptr[virt_idx];
		next_ptr_val = virt_ptr;
		next_addr = raw_addr;
		if (virt_hit) begin
			case (virt_kind)
				IND_AFTER_ACCESS_INCREMENT: begin
					next_addr    = virt_ptr;
					next_ptr_val = virt_ptr + 12'h001;
				end
				IND_AFTER_ACCESS_DECREMENT: begin
					next_addr    = virt_ptr;
					next_ptr_val = virt_ptr - 12'h001;
				end
				IND_BEFORE_ACCESS_INCREMENT: begin
					next_addr    = virt_ptr + 12'h001;
					next_ptr_val = virt_ptr + 12'h001;
				end
				IND_ACCUMULATOR_OFFSET_OPERAND:   next_addr = virt_ptr + {{4{acc[7]}}, acc};
				default:     next_addr = virt_ptr;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequencer and latched instruction
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:  if (take) state <= ST_EXEC;
				ST_EXEC:  state <= ST_WRITE;
				ST_WRITE: state <= ST_IDLE;
				default:  state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q      <= OP_NOP;
			lit_q     <= 8'h00;
			wr_file_q <= 1'b0;
			sel_q     <= SEL_RAM;
			sel_idx_q <= 2'b00;
			mem_addr  <= 12'h000;
			mem_re    <= 1'b0;
		end else if (take) begin
			op_q      <= instr_op;
			lit_q     <= instr_file;
			// The destination bit chooses, otherwise the opcode fixes the target.
			wr_file_q <= !afda_is_literal(instr_op) &&
				(instr_has_dest ? instr_dest : instr_impl_file);
			sel_q     <= sfr_sel(next_addr);
			sel_idx_q <= next_addr[2:1];
			mem_addr  <= next_addr;
			mem_re    <= !afda_is_literal(instr_op) && (sfr_sel(next_addr) == SEL_RAM);
		end else if (state == ST_EXEC) begin
			mem_re    <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jump_valid  <= 1'b0;
			jump_target <= 20'h00000;
		end else begin
			jump_valid <= take && (instr_op == OP_LJMP);
			if (take && instr_op == OP_LJMP)
				jump_target <= {instr_jump_hi, instr_file};
		end
	end

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	always_comb begin
		case (sel_q)
			SEL_FLAGS:  src = {3'b000, flags};
			SEL_ACC:    src = acc;
			SEL_BANK:   src = {4'h0, bank};
			SEL_PTR_LO: src = ptr[sel_idx_q][7:0];
			SEL_PTR_HI: src = {4'h0, ptr[sel_idx_q][11:8]};
			default:    src = mem_rdata;
		endcase
	end

	assign alu_bus.op       = op_q;
	assign alu_bus.a        = afda_is_literal(op_q) ? lit_q : src;
	assign alu_bus.b        = acc;
	assign alu_bus.carry_in = flags[FL_C];

	assign wr_acc      = !wr_file_q && (op_q != OP_NOP) && (op_q != OP_LJMP);
	assign flag_target = wr_file_q && (sel_q == SEL_FLAGS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_we     <= 1'b0;
			mem_wdata  <= 8'h00;
			instr_done <= 1'b0;
		end else begin
			mem_we     <= (state == ST_EXEC) && wr_file_q && (sel_q == SEL_RAM);
			instr_done <= (state == ST_EXEC);
			if (state == ST_EXEC)
				mem_wdata <= alu_bus.result;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	assign apb_wr  = psel && penable && pwrite && pready && !pslverr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= FLAGS_RST;
		end else if (state == ST_EXEC && flag_target && alu_bus.mask == 5'h00) begin
			flags <= alu_bus.result[4:0];
		end else if (state == ST_EXEC) begin
			// A flag destination keeps only the operation's flag effects.
			flags <= (flags & ~alu_bus.mask) | (alu_bus.flags & alu_bus.mask);
		end else if (apb_wr && paddr == OFS_FLAGS) begin
			flags <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= ACC_RST;
		end else if (state == ST_EXEC && (wr_acc || (wr_file_q && sel_q == SEL_ACC))) begin
			acc <= alu_bus.result;
		end else if (apb_wr && paddr == OFS_ACC) begin
			acc <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank <= BANK_RST;
		end else if (state == ST_EXEC && wr_file_q && sel_q == SEL_BANK) begin
			bank <= alu_bus.result[3:0];
		end else if (apb_wr && paddr == OFS_BANK) begin
			bank <= pwdata[3:0];
		end
	end

	// Pointer updates happen when the instruction is taken, so a pre-increment already
	// addresses the new value; direct writes land in the execute cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_PTR; i++)
				ptr[i] <= PTR_RST;
		end else begin
			for (int i = 0; i < N_PTR; i++) begin
				if (take && virt_hit && virt_idx == 2'(i) && !afda_is_literal(instr_op))
					ptr[i] <= next_ptr_val;
				else if (state == ST_EXEC && wr_file_q && sel_idx_q == 2'(i) && sel_q == SEL_PTR_LO)
					ptr[i][7:0] <= alu_bus.result;
				else if (state == ST_EXEC && wr_file_q && sel_idx_q == 2'(i) && sel_q == SEL_PTR_HI)
					ptr[i][11:8] <= alu_bus.result[3:0];
				else if (apb_wr && paddr == 8'(OFS_PTR0 + 8'(4 * i)))
					ptr[i] <= pwdata[11:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_en <= CFG_RST;
		else if (apb_wr && paddr == OFS_CFG)
			ext_en <= pwdata[CFG_EXT];
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign apb_hit = (paddr == OFS_FLAGS) || (paddr == OFS_ACC) || (paddr == OFS_BANK) ||
		(paddr == OFS_PTR0) || (paddr == OFS_PTR1) || (paddr == OFS_PTR2) ||
		(paddr == OFS_CFG) || (paddr == OFS_STAT);

	// Writes wait for an idle core so software never races an instruction in flight.
	assign pready  = !pwrite || (instr_ready && !instr_valid);
	assign pslverr = psel && penable && pready && !apb_hit;

	always_comb begin
		case (paddr)
			OFS_FLAGS: rd_mux = {3'b000, flags};
			OFS_ACC:   rd_mux = acc;
			OFS_BANK:  rd_mux = {4'h0, bank};
			OFS_CFG:   rd_mux = {7'h00, ext_en};
			OFS_STAT:  rd_mux = {6'h00, mem_re, !instr_ready};
			default:   rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == OFS_PTR0)
				prdata <= {20'h00000, ptr[0]};
			else if (paddr == OFS_PTR1)
				prdata <= {20'h00000, ptr[1]};
			else if (paddr == OFS_PTR2)
				prdata <= {20'h00000, ptr[2]};
			else
				prdata <= {24'h000000, rd_mux};
		end
	end

endmodule
`default_nettype wire

// File: verification/afda_core_properties.sv
// Concurrent checks on the instruction side of the core.
// Assumes one clock domain; bound to every afda_core below.
`timescale 1ns/1ns
`default_nettype none
module afda_core_props
	import afda_pkg::*;
(
	input wire logic               pclk,            // Clock.
	input wire logic               presetn,         // Reset, active low.
	input wire logic               instr_valid,     // Offer.
	input wire logic               instr_ready,     // Idle.
	input wire afda_pkg::afda_op_e instr_op,        // Operation.
	input wire logic [7:0]         instr_file,      // File address.
	input wire logic               instr_access,    // Access bit.
	input wire logic               instr_dest,      // Destination bit.
	input wire logic               instr_has_dest,  // Has destination.
	input wire logic               instr_impl_file, // Implicit file target.
	input wire logic               instr_full,      // Full address given.
	input wire logic [11:0]        instr_full_addr, // Full address.
	input wire logic [11:0]        mem_addr,        // RAM address.
	input wire logic               mem_we           // RAM write.
);
	// ----------------------------------------------------------------
	// Addressing and write-back
	// ----------------------------------------------------------------
	// Plain RAM ranges only; the access-bank SFR corner is left out.
	wire logic lo = instr_file inside {[8'h60:8'h7F]} && !instr_access;
	wire logic hi = instr_file inside {[8'h80:8'hBF]} && !instr_access;
	wire logic rd = instr_op inside {OP_ADD, OP_SUB, OP_MOVF};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take; instr_valid && instr_ready && !instr_full; endsequence
	sequence s_no_wr; !mem_we [*2]; endsequence
	property p_acc_lo; s_take ##0 (lo && rd) |=> mem_addr == {4'h0, $past(instr_file)}; endproperty
	a_acc_lo: assert property (p_acc_lo) else $error("low access bank address wrong");
	property p_acc_hi; s_take ##0 (hi && rd) |=> mem_addr == {4'hF, $past(instr_file)}; endproperty
	a_acc_hi: assert property (p_acc_hi) else $error("high access bank address wrong");
	property p_full;
		instr_valid && instr_ready && instr_full && instr_op == OP_MOVF |=> mem_addr == $past(instr_full_addr);
	endproperty
	a_full: assert property (p_full) else $error("full address not used");
	property p_dest_file;
		s_take ##0 (lo && instr_op == OP_ADD && instr_has_dest && instr_dest)
			|=> !mem_we ##1 (mem_we && mem_addr == {4'h0, $past(instr_file, 2)});
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("file write-back missing");
	property p_dest_acc; s_take ##0 (instr_has_dest && !instr_dest) |=> s_no_wr; endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("RAM written for accumulator result");
	property p_impl;
		s_take ##0 (lo && instr_op == OP_STORE && !instr_has_dest && instr_impl_file) |-> ##2 mem_we;
	endproperty
	a_impl: assert property (p_impl) else $error("implicit file target not written");
	property p_literal; s_take ##0 (instr_op inside {OP_ADDL, OP_SUBL, OP_MOVL, OP_LJMP}) |=> s_no_wr; endproperty
	a_literal: assert property (p_literal) else $error("literal operation wrote RAM");
	property p_we_hold; mem_we |-> $stable(mem_addr); endproperty
	a_we_hold: assert property (p_we_hold) else $error("address moved during write");
endmodule
bind afda_core afda_core_props u_props (.*);
`default_nettype wire

// File: verification/afda_ram_model.sv
// Behavioural data RAM facing the core's memory port.
// Reads are combinational while the strobe is high; writes land on the edge.
`timescale 1ns/1ns
`default_nettype none
module afda_ram_model (
	input  wire logic [11:0] mem_addr,  // Address.
	input  wire logic        pclk,      // Clock.
	input  wire logic        mem_re,    // Read strobe.
	input  wire logic        mem_we,    // Write pulse.
	input  wire logic [7:0]  mem_wdata, // Write data.
	output logic      [7:0]  mem_rdata  // Read data.
);
	logic [7:0] mem [4096];
	// Without a read strobe the word shows inverted, so a late sample is caught.
	assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ {4'h5, i[11:8]};
		end
	end
	always @(posedge pclk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

// File: verification/alu_flags_and_data_addressing_tb.sv
// Self-checking bench: APB register access and instruction runs.
// Assumes the RAM model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module alu_flags_and_data_addressing_tb;
	import afda_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic        instr_valid = 0, instr_access = 0, instr_dest = 0, instr_has_dest = 1, instr_impl_file = 0;
	logic        instr_full = 0, instr_ready, instr_done, jump_valid, mem_re, mem_we;
	logic [7:0]  paddr = 0, instr_file = 0, mem_wdata, mem_rdata, acc;
	logic [31:0] pwdata = 0, prdata, q;
	logic [11:0] instr_full_addr = 0, instr_jump_hi = 0, mem_addr;
	logic [19:0] jump_target, jt;
	logic [12:0] e;
	logic [4:0]  ef;
	afda_op_e    instr_op = OP_NOP;
	afda_op_e    to [10] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_ADDL, OP_SUBL, OP_AND, OP_XOR, OP_RLC, OP_RRC};
	logic [7:0]  tx [10] = '{8'h70, 8'hFF, 8'h05, 8'h00, 8'h8F, 8'h10, 8'hF0, 8'h55, 8'h89, 8'h08};
	logic [7:0]  tw [10] = '{8'h10, 8'h01, 8'h05, 8'h01, 8'h88, 8'h20, 8'h8F, 8'h55, 8'h00, 8'h00};
	logic [11:0] tea [5] = '{12'h0FF, 12'h0FF, 12'h100, 12'h100, 12'h0FE};
	logic [11:0] tnp [5] = '{12'h0FF, 12'h100, 12'h0FF, 12'h100, 12'h100};
	int          mismatches = 0, n_compared = 0;
	always #5 pclk = ~pclk;
	afda_core DUT (.*);
	afda_ram_model u_ram (.*);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ex(input afda_op_e o, input logic [7:0] f, input logic a, input logic d);
		@(posedge pclk);
		instr_valid  <= 1'b1;
		instr_op     <= o;
		instr_file   <= f;
		instr_access <= a;
		instr_dest   <= d;
		do @(posedge pclk); while (instr_ready !== 1'b1);
		instr_valid <= 1'b0;
		do begin
			@(posedge pclk);
			if (jump_valid === 1'b1) jt = jump_target;
		end while (instr_done !== 1'b1);
	endtask
	task automatic ld(input logic [7:0] f, input logic a, input logic [11:0] ea);
		ex(OP_MOVF, f, a, 1'b0);
		apb(1'b0, OFS_ACC, 0);
		chk(q, {24'h0, ea[7:0] ^ {4'h5, ea[11:8]}});
	endtask
	// Returns {result, flags}; flags an operation does not own keep their old value.
	function automatic logic [12:0] alu(input afda_op_e o, input logic [7:0] x, w, input logic [4:0] fl);
		logic [7:0] b, r;
		logic [8:0] s;
		logic [4:0] h, n;
		logic       sb;
		sb = o inside {OP_SUB, OP_SUBL};
		b  = sb ? ~w : w;
		s  = {1'b0, x} + {1'b0, b} + 9'(sb);
		h  = {1'b0, x[3:0]} + {1'b0, b[3:0]} + 5'(sb);
		case (o)
			OP_AND:  r = x & w;
			OP_XOR:  r = x ^ w;
			OP_RLC:  r = {x[6:0], fl[0]};
			OP_RRC:  r = {fl[0], x[7:1]};
			default: r = s[7:0];
		endcase
		n = {r[7], fl[3], r == 8'h00, fl[1:0]};
		if (o inside {OP_RLC, OP_RRC}) n[1:0] = (o == OP_RLC) ? {x[3], x[7]} : {x[4], x[0]};
		if (sb || o inside {OP_ADD, OP_ADDL}) n = {r[7], x[7] == b[7] && r[7] != x[7], r == 8'h00, h[4], s[8]};
		return {r, n};
	endfunction
	task automatic report_and_stop;
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	// About sixtyfold margin: 20,000 cycles over the roughly 310-cycle sequence.
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h40, 0);
		chk({q[30:0], err}, 32'h1);
		apb(1'b1, OFS_FLAGS, 32'hFF);
		apb(1'b0, OFS_FLAGS, 0);
		chk(q, 32'h1F);
		ef = 5'h1F;
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, OFS_ACC, {24'h0, tw[i]});
			u_ram.mem[12'h065] = tx[i];
			ex(to[i], to[i] inside {OP_ADDL, OP_SUBL} ? tx[i] : 8'h65, 1'b0, 1'b0);
			e  = alu(to[i], tx[i], tw[i], ef);
			ef = e[4:0];
			apb(1'b0, OFS_FLAGS, 0);
			chk(q, {27'h0, ef});
			apb(1'b0, OFS_ACC, 0);
			chk(q, {24'h0, e[12:5]});
		end
		acc = e[12:5];
		ex(OP_ADD, 8'hF0, 1'b0, 1'b1);
		e  = alu(OP_ADD, {3'h0, ef}, acc, ef);
		ef = e[4:0];
		apb(1'b0, OFS_FLAGS, 0);
		chk(q, {27'h0, ef});
		instr_has_dest  <= 1'b0;
		instr_impl_file <= 1'b1;
		ex(OP_CLR, 8'hF0, 1'b0, 1'b0);
		apb(1'b0, OFS_FLAGS, 0);
		chk(q, {27'h0, ef | 5'h04});
		ex(OP_STORE, 8'h67, 1'b0, 1'b0);
		@(posedge pclk);
		chk({24'h0, u_ram.mem[12'h067]}, {24'h0, acc});
		instr_has_dest  <= 1'b1;
		instr_impl_file <= 1'b0;
		apb(1'b1, OFS_ACC, 32'h22);
		ex(OP_ADD, 8'h66, 1'b0, 1'b1);
		@(posedge pclk);
		chk({24'h0, u_ram.mem[12'h066]}, 32'h58);
		apb(1'b1, OFS_BANK, 32'h3);
		ld(8'h22, 1'b1, 12'h322);
		ld(8'h22, 1'b0, 12'h022);
		ld(8'hA0, 1'b0, 12'hFA0);
		instr_full      <= 1'b1;
		instr_full_addr <= 12'h456;
		ld(8'h22, 1'b1, 12'h456);
		instr_full <= 1'b0;
		apb(1'b1, OFS_CFG, 32'h1);
		apb(1'b1, OFS_PTR2, 32'h200);
		ld(8'h10, 1'b0, 12'h210);
		ld(8'h60, 1'b0, 12'h060);
		apb(1'b1, OFS_CFG, 32'h0);
		ld(8'h10, 1'b0, 12'h010);
		apb(1'b1, OFS_PTR0, 32'hFF);
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, OFS_ACC, 32'hFE);
			ld(8'hD0 + 8'(k), 1'b0, tea[k]);
			apb(1'b0, OFS_PTR0, 0);
			chk(q, {20'h0, tnp[k]});
		end
		ex(OP_MOVF, 8'hC1, 1'b0, 1'b0);
		apb(1'b0, OFS_ACC, 0);
		chk(q, 32'h1);
		instr_jump_hi <= 12'hABC;
		ex(OP_LJMP, 8'h12, 1'b0, 1'b0);
		chk({12'h0, jt}, 32'hABC12);
		report_and_stop();
	end
endmodule
`default_nettype wire
